// ==== hw/mic_pkg.sv ====
`default_nettype none
package mic_pkg;
	localparam int NSRC = 14;
	localparam logic [11:0] ADDR_SENS = 12'h000;
	localparam logic [11:0] ADDR_PSEL = 12'h004;
	localparam logic [11:0] ADDR_CTRL = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [7:0] SENS_RST = 8'h00;
	localparam logic [7:0] PSEL_RST = 8'h0C;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
	localparam logic [1:0] SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] SENS_RISE = 2'h1;
	localparam logic [1:0] SENS_FALL = 2'h2;
	localparam logic [1:0] SENS_BOTH = 2'h3;
	localparam int SRC_AWU = 0;
	localparam int SRC_EXT0 = 1;
	localparam int SRC_VDET = 7;
	// Halt and active-halt exit capability per source; the wake logic also lets SRC_AWU exit active halt
	localparam logic [13:0] HALT_EXIT = 14'h101E;
	localparam logic [13:0] AHALT_EXIT = 14'h0A00;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
	typedef enum logic [1:0] {MIC_RUN, MIC_WAIT, MIC_HALT, MIC_AHALT} mic_mode_e;
	typedef struct packed {
		logic trapReq;
		logic entryAck;
		logic returnDone;
	} mic_core_s;
	typedef struct packed {
		logic irqValid;
		logic trapTake;
		logic [15:0] vector;
		logic [3:0] source;
	} mic_take_s;
endpackage
`default_nettype wire

// ==== hw/mic_ctrl.sv ====
// Local design decisions: the register addresses and the APB interface to the registers.
`default_nettype none
module mic_ctrl
	import mic_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  portA,
	input  wire logic [7:0]  portB,
	input  wire logic [13:0] periphFlag,
	input  wire logic [13:0] periphEnable,
	input  wire logic [13:0] periphClear,
	input  wire logic        condCodeMaskSet,
	input  wire logic        instrBoundary,
	input  wire mic_core_s   core,
	input  wire mic_mode_e   lowPowerMode,
	output mic_take_s        take,
	output logic             maskBit,
	output logic             wakeUp
);
	logic [7:0]  sens;
	logic [7:0]  pinSel;
	logic [3:0]  extPin;
	logic [3:0]  sync1;
	logic [3:0]  sync2;
	logic [3:0]  prevPin;
	logic [13:0] pending;
	logic [13:0] eligible;
	logic        inService;
	logic        regWrite;
	logic [3:0]  winner;
	logic        anyElig;
	// External lines carry no enable bit of their own
	localparam logic [13:0] EXT_LINES = 14'h001E;

	function automatic logic [1:0] field(input logic [7:0] r, input int line);
		field = r[line*2 +: 2];
	endfunction

	function automatic logic lowerSet(input logic [13:0] e, input logic [3:0] s);
		lowerSet = |(e & ((14'h0001 << s) - 14'h0001));
	endfunction

	// Line routing from the selected port pins
	always_comb begin
		unique case (field(pinSel, 3))
			2'h0: extPin[3] = portB[0];
			2'h1: extPin[3] = portB[1];
			2'h2: extPin[3] = portB[2];
			default: extPin[3] = 1'b1;
		endcase
		extPin[2] = portB[3 + field(pinSel, 2)];
		extPin[1] = portA[4 + field(pinSel, 1)];
		extPin[0] = portA[field(pinSel, 0)];
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			// Idle high, so reset makes no false edge or low level
			sync1 <= 4'hF;
			sync2 <= 4'hF;
			prevPin <= 4'hF;
		end else begin
			sync1 <= extPin;
			sync2 <= sync1;
			prevPin <= sync2;
		end
	end

	assign regWrite = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sens <= SENS_RST;
			pinSel <= PSEL_RST;
		end else if (regWrite) begin
			if (paddr == ADDR_SENS && maskBit)
				sens <= pwdata[7:0];
			if (paddr == ADDR_PSEL)
				pinSel <= pwdata[7:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ADDR_SENS: prdata <= {24'h000000, sens};
				ADDR_PSEL: prdata <= {24'h000000, pinSel};
				ADDR_CTRL: prdata <= {30'h0, inService, maskBit};
				ADDR_STAT: prdata <= {18'h0, pending};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Mask bit mirrors the core; held set through reset and service
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			maskBit <= 1'b1;
			inService <= 1'b0;
		end else if (core.entryAck) begin
			maskBit <= 1'b1;
			inService <= 1'b1;
		end else if (core.returnDone) begin
			maskBit <= 1'b0;
			inService <= 1'b0;
		end else if (!inService) begin
			maskBit <= condCodeMaskSet;
		end
	end

	// Pending latches; set wins over every clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pending <= 14'h0000;
		end else begin
			for (int s = 0; s < NSRC; s++) begin
				logic hit;
				logic clr;
				logic [1:0] f;
				hit = 1'b0;
				clr = 1'b0;
				f = 2'h0;
				if (s >= SRC_EXT0 && s < SRC_EXT0 + 4) begin
					f = field(sens, s - SRC_EXT0);
					unique case (f)
						SENS_FALL_LOW: hit = !sync2[s-SRC_EXT0];
						SENS_RISE: hit = sync2[s-SRC_EXT0] && !prevPin[s-SRC_EXT0];
						SENS_FALL: hit = !sync2[s-SRC_EXT0] && prevPin[s-SRC_EXT0];
						SENS_BOTH: hit = sync2[s-SRC_EXT0] != prevPin[s-SRC_EXT0];
					endcase
					if (regWrite && paddr == ADDR_SENS && maskBit
						&& field(pwdata[7:0], s - SRC_EXT0) != f)
						clr = 1'b1;
				end else begin
					hit = periphFlag[s];
					clr = periphClear[s];
				end
				if (core.entryAck && take.source == 4'(s) && !take.trapTake)
					clr = 1'b1;
				if (hit)
					pending[s] <= 1'b1;
				else if (clr)
					pending[s] <= 1'b0;
			end
		end
	end

	// External lines are always enabled; peripherals need their enable
	assign eligible = pending & (periphEnable | EXT_LINES);

	always_comb begin
		winner = 4'h0;
		anyElig = 1'b0;
		for (int s = NSRC - 1; s >= 0; s--) begin
			if (eligible[s]) begin
				winner = 4'(s);
				anyElig = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			take <= '0;
		end else if (core.entryAck) begin
			take <= '0;
		end else if (instrBoundary && !take.irqValid && !take.trapTake) begin
			if (core.trapReq) begin
				take.trapTake <= 1'b1;
				take.vector <= VEC_TRAP;
				take.source <= 4'h0;
			end else if (anyElig && !maskBit) begin
				take.irqValid <= 1'b1;
				take.vector <= VEC_SRC0 - {11'h0, winner, 1'b0};
				take.source <= winner;
			end
		end
	end

	// Wake decision per low-power mode
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wakeUp <= 1'b0;
		end else begin
			unique case (lowPowerMode)
				MIC_RUN: wakeUp <= 1'b0;
				MIC_WAIT: wakeUp <= |eligible;
				MIC_HALT: wakeUp <= |(eligible & HALT_EXIT & ~14'h0001)
					&& !(eligible[3] && field(pinSel, 2) == 2'h1);
				MIC_AHALT: wakeUp <= |(eligible & (AHALT_EXIT | 14'h0001));
			endcase
		end
	end

	property p_masked;
		@(posedge clock) disable iff (!rstn)
		maskBit && !core.entryAck |=> !$rose(take.irqValid);
	endproperty
	a_masked: assert property (p_masked) else $error("vector taken while masked");

	property p_resetmask;
		@(posedge clock) $rose(rstn) |-> maskBit;
	endproperty
	a_resetmask: assert property (p_resetmask) else $error("mask clear after reset");

	property p_entry;
		@(posedge clock) disable iff (!rstn)
		core.entryAck |=> maskBit && !take.irqValid;
	endproperty
	a_entry: assert property (p_entry) else $error("entry did not set mask");

	property p_return;
		@(posedge clock) disable iff (!rstn)
		core.returnDone && !core.entryAck |=> !maskBit;
	endproperty
	a_return: assert property (p_return) else $error("return kept mask set");

	property p_trap;
		@(posedge clock) disable iff (!rstn)
		core.trapReq && instrBoundary && !take.irqValid && !take.trapTake && !core.entryAck
		|=> take.trapTake && take.vector == VEC_TRAP;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not taken");

	property p_vector;
		@(posedge clock) disable iff (!rstn)
		$rose(take.irqValid) |-> take.vector == VEC_SRC0 - {11'h0, take.source, 1'b0};
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");

	property p_sensgate;
		@(posedge clock) disable iff (!rstn)
		regWrite && paddr == ADDR_SENS && !maskBit |=> $stable(sens);
	endproperty
	a_sensgate: assert property (p_sensgate) else $error("sensitivity written unmasked");

	property p_level;
		@(posedge clock) disable iff (!rstn)
		field(sens, 0) == SENS_FALL_LOW && !sync2[0] |=> pending[SRC_EXT0];
	endproperty
	a_level: assert property (p_level) else $error("low level not pending");

	property p_takehold;
		@(posedge clock) disable iff (!rstn)
		take.irqValid && !core.entryAck |=> take.irqValid;
	endproperty
	a_takehold: assert property (p_takehold) else $error("request dropped early");

	property p_takeclear;
		@(posedge clock) disable iff (!rstn)
		core.entryAck |=> !take.irqValid && !take.trapTake;
	endproperty
	a_takeclear: assert property (p_takeclear) else $error("take kept after entry");

	property p_vecstable;
		@(posedge clock) disable iff (!rstn)
		take.irqValid && !core.entryAck |=> $stable(take.vector);
	endproperty
	a_vecstable: assert property (p_vecstable) else $error("vector moved");

	property p_trapvec;
		@(posedge clock) disable iff (!rstn)
		$rose(take.trapTake) |-> take.vector == VEC_TRAP;
	endproperty
	a_trapvec: assert property (p_trapvec) else $error("wrong trap vector");

	property p_prio;
		@(posedge clock) disable iff (!rstn)
		$rose(take.irqValid) |-> !lowerSet($past(eligible), take.source);
	endproperty
	a_prio: assert property (p_prio) else $error("higher source passed over");

	property p_picked;
		@(posedge clock) disable iff (!rstn)
		$rose(take.irqValid) |-> |($past(eligible) & (14'h0001 << take.source));
	endproperty
	a_picked: assert property (p_picked) else $error("source not eligible");

	property p_rstregs;
		@(posedge clock) $rose(rstn) |-> sens == SENS_RST && pinSel == PSEL_RST;
	endproperty
	a_rstregs: assert property (p_rstregs) else $error("register reset value");

	property p_rstidle;
		@(posedge clock)
		$rose(rstn) |-> !take.irqValid && !take.trapTake && pending == '0 && !wakeUp;
	endproperty
	a_rstidle: assert property (p_rstidle) else $error("busy after reset");

	property p_unmasked;
		@(posedge clock) disable iff (!rstn)
		$rose(take.irqValid) |-> !$past(maskBit);
	endproperty
	a_unmasked: assert property (p_unmasked) else $error("taken under mask");

	property p_nopreempt;
		@(posedge clock) disable iff (!rstn)
		inService |-> !take.irqValid;
	endproperty
	a_nopreempt: assert property (p_nopreempt) else $error("routine pre-empted");

	property p_senswrite;
		@(posedge clock) disable iff (!rstn)
		regWrite && paddr == ADDR_SENS && maskBit |=> sens == $past(pwdata[7:0]);
	endproperty
	a_senswrite: assert property (p_senswrite) else $error("sensitivity write lost");

	property p_pselwrite;
		@(posedge clock) disable iff (!rstn)
		regWrite && paddr == ADDR_PSEL |=> pinSel == $past(pwdata[7:0]);
	endproperty
	a_pselwrite: assert property (p_pselwrite) else $error("pin select write lost");

	property p_sensclear;
		@(posedge clock) disable iff (!rstn)
		regWrite && paddr == ADDR_SENS && maskBit && field(pwdata[7:0], 0) != field(sens, 0)
		&& sync2[0] && prevPin[0] |=> !pending[SRC_EXT0];
	endproperty
	a_sensclear: assert property (p_sensclear) else $error("pending kept on change");

	property p_rise;
		@(posedge clock) disable iff (!rstn)
		field(sens, 0) == SENS_RISE && sync2[0] && !prevPin[0] |=> pending[SRC_EXT0];
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");

	property p_fall;
		@(posedge clock) disable iff (!rstn)
		field(sens, 0) == SENS_FALL && !sync2[0] && prevPin[0] |=> pending[SRC_EXT0];
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge missed");

	property p_lowrise;
		@(posedge clock) disable iff (!rstn)
		field(sens, 0) == SENS_RISE && !sync2[0] && !pending[SRC_EXT0] |=> !pending[SRC_EXT0];
	endproperty
	a_lowrise: assert property (p_lowrise) else $error("low pin requested");

	property p_vdetclr;
		@(posedge clock) disable iff (!rstn)
		core.entryAck && take.irqValid && take.source == 4'(SRC_VDET) && !periphFlag[SRC_VDET]
		|=> !pending[SRC_VDET];
	endproperty
	a_vdetclr: assert property (p_vdetclr) else $error("voltage pending kept");

	property p_vdetset;
		@(posedge clock) disable iff (!rstn)
		periphFlag[SRC_VDET] |=> pending[SRC_VDET];
	endproperty
	a_vdetset: assert property (p_vdetset) else $error("flag not latched");

	property p_wakewait;
		@(posedge clock) disable iff (!rstn)
		lowPowerMode == MIC_WAIT && |eligible |=> wakeUp;
	endproperty
	a_wakewait: assert property (p_wakewait) else $error("wait not exited");

	property p_wakerun;
		@(posedge clock) disable iff (!rstn)
		lowPowerMode == MIC_RUN |=> !wakeUp;
	endproperty
	a_wakerun: assert property (p_wakerun) else $error("wake while running");

	property p_wakehalt;
		@(posedge clock) disable iff (!rstn)
		lowPowerMode == MIC_HALT && (eligible & HALT_EXIT) == '0 |=> !wakeUp;
	endproperty
	a_wakehalt: assert property (p_wakehalt) else $error("halt exited wrongly");

	property p_wakeahalt;
		@(posedge clock) disable iff (!rstn)
		lowPowerMode == MIC_AHALT && (eligible & (AHALT_EXIT | (14'h0001 << SRC_AWU))) == '0
		|=> !wakeUp;
	endproperty
	a_wakeahalt: assert property (p_wakeahalt) else $error("active halt exited");

	property p_pinfour;
		@(posedge clock) disable iff (!rstn)
		lowPowerMode == MIC_HALT && field(pinSel, 2) == 2'h1
		&& eligible == (14'h0001 << (SRC_EXT0 + 2)) |=> !wakeUp;
	endproperty
	a_pinfour: assert property (p_pinfour) else $error("port B bit four woke halt");
endmodule
`default_nettype wire

// ==== verification/mic_core_model.sv ====
`default_nettype none
module mic_core_model
	import mic_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rstn,
	input  wire mic_take_s take,
	input  wire logic      trapCmd,
	input  wire logic      returnCmd,
	input  wire logic      slow,
	output mic_core_s      core,
	output logic           instrBoundary
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] waitCount;
	// Every cycle ends an instruction in this model
	assign instrBoundary = 1'b1;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			core      <= '0;
			waitCount <= 2'h0;
		end else begin
			core.trapReq    <= trapCmd;
			core.returnDone <= returnCmd;
			core.entryAck   <= 1'b0;
			// Push then load vector; slow mode stretches the stacking
			if ((take.irqValid || take.trapTake) && !core.entryAck) begin
				if (waitCount == (slow ? 2'h3 : 2'h0)) begin
					core.entryAck <= 1'b1;
					waitCount     <= 2'h0;
				end else begin
					waitCount <= waitCount + 2'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/test_mcu_interrupt_controller.sv ====
`default_nettype none
module test_mcu_interrupt_controller import mic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        mask;
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  exp;
	} mic_row_s;
	logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
	logic        cmask, trapCmd, returnCmd, slow, maskBit, wakeUp, instrBoundary, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  portA, portB;
	logic [13:0] pFlag, pEn, pClr;
	mic_core_s   core;
	mic_mode_e   mode;
	mic_take_s   take;
	int          failures, checkCount;
	mic_row_s    rows [6] = '{
		'{1'b1, ADDR_SENS, 8'hB4, 8'hB4}, '{1'b1, ADDR_PSEL, 8'h9E, 8'h9E},
		'{1'b0, ADDR_SENS, 8'h03, 8'hB4}, '{1'b1, 12'h010, 8'h5A, 8'h00},
		'{1'b1, ADDR_SENS, 8'h02, 8'h02}, '{1'b1, ADDR_PSEL, 8'h00, 8'h00}};
	mic_ctrl dut (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portA(portA), .portB(portB), .periphFlag(pFlag), .periphEnable(pEn),
		.periphClear(pClr), .condCodeMaskSet(cmask), .instrBoundary(instrBoundary),
		.core(core), .lowPowerMode(mode), .take(take), .maskBit(maskBit), .wakeUp(wakeUp));
	mic_core_model partner (.clock(clock), .rstn(rstn), .take(take), .trapCmd(trapCmd),
		.returnCmd(returnCmd), .slow(slow), .core(core), .instrBoundary(instrBoundary));
	always #5 clock = ~clock;
	task automatic conclude();
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clock);
		{paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 1'b1, 1'b0};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		{psel, penable} <= 2'b00;
		if (n == 50) begin
			failures++;
			conclude();
		end
	endtask
	task automatic service(input logic [15:0] vec);
		int n;
		n = 0;
		while (take.irqValid !== 1'b1 && take.trapTake !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		check({16'h0000, take.vector}, {16'h0000, vec});
		// Drop the sources before entry so only latched pending survives
		@(posedge clock);
		{pFlag, trapCmd} <= '0;
		while (core.entryAck !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		check({31'h0, maskBit}, 32'h1);
		@(posedge clock);
		returnCmd <= 1'b1;
		@(posedge clock);
		returnCmd <= 1'b0;
		if (n == 200) begin
			failures++;
			conclude();
		end
	endtask
	task automatic wake(input logic e);
		repeat (3) @(negedge clock);
		check({31'h0, wakeUp}, {31'h0, e});
		@(posedge clock);
	endtask
	task automatic noTake();
		seen = 1'b0;
		repeat (30) begin
			@(negedge clock);
			seen = seen | take.irqValid;
		end
		check({31'h0, seen}, 32'h0);
		@(posedge clock);
	endtask
	function automatic logic [15:0] vecOf(input int s);
		return VEC_SRC0 - 16'(2 * s);
	endfunction
	initial begin
		{clock, rstn, psel, penable, pwrite, trapCmd, returnCmd} = '0;
		{paddr, pwdata, pFlag, pEn, pClr, failures, checkCount} = '0;
		{cmask, slow, portA, portB} = {2'b11, 8'hFF, 8'hFF};
		mode = MIC_RUN;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(negedge clock);
		check({31'h0, maskBit}, 32'h1);
		apb(ADDR_SENS, 1'b0, 32'h0);
		check(rd, {24'h0, SENS_RST});
		apb(ADDR_PSEL, 1'b0, 32'h0);
		check(rd, 32'h0000000C);
		$display("reset test done");
		foreach (rows[i]) begin
			cmask <= rows[i].mask;
			repeat (3) @(posedge clock);
			apb(rows[i].addr, 1'b1, {24'h0, rows[i].wdata});
			apb(rows[i].addr, 1'b0, 32'h0);
			check(rd, {24'h0, rows[i].exp});
		end
		$display("register rows done");
		slow <= 1'b0;
		cmask <= 1'b0;
		portA <= 8'hFE;
		service(vecOf(1));
		noTake();
		$display("external edge test done");
		slow <= 1'b1;
		pEn <= 14'h3FFF;
		pFlag <= 14'h1020;
		service(vecOf(5));
		service(vecOf(12));
		pEn <= 14'h0000;
		pFlag <= 14'h0100;
		noTake();
		pEn <= 14'h0100;
		service(vecOf(8));
		cmask <= 1'b1;
		repeat (3) @(posedge clock);
		pEn <= 14'h3FFF;
		pFlag <= 14'h0400;
		noTake();
		trapCmd <= 1'b1;
		service(VEC_TRAP);
		cmask <= 1'b0;
		service(vecOf(10));
		pEn <= 14'h0000;
		pFlag <= 14'h0800;
		@(posedge clock);
		{pFlag, pClr} <= {14'h0000, 14'h0800};
		@(posedge clock);
		{pClr, pEn} <= {14'h0000, 14'h3FFF};
		noTake();
		$display("priority and mask tests done");
		cmask <= 1'b1;
		repeat (3) @(posedge clock);
		apb(ADDR_SENS, 1'b1, {24'h0, SENS_RST});
		cmask <= 1'b0;
		service(vecOf(1));
		portA <= 8'hFF;
		service(vecOf(1));
		noTake();
		$display("level test done");
		cmask <= 1'b1;
		repeat (3) @(posedge clock);
		pFlag <= 14'h0100;
		mode <= MIC_WAIT;
		wake(1'b1);
		mode <= MIC_HALT;
		wake(1'b0);
		mode <= MIC_AHALT;
		wake(1'b0);
		pFlag <= 14'h1300;
		wake(1'b1);
		mode <= MIC_HALT;
		wake(1'b1);
		{pFlag, pClr} <= {14'h0000, 14'h1300};
		mode <= MIC_RUN;
		wake(1'b0);
		pClr <= 14'h0000;
		$display("wake test done");
		conclude();
	end
endmodule
`default_nettype wire
